// ---- logic/config_loader_pkg.sv ----
// Constants and types shared by the configuration source loader
//
// Contract
// R1: Card boot reads bitstream through card controller
// R2: SD cards four bits, MMC eight bits
// R3: Received flag rises after error-free full bitstream
// R4: User-mode flag rises only in user mode
// R5: Scan port wins over boot-source select
// R6: Security lock refuses configuration over scan port
// R7: Programmer bypasses every other chain device
// R8: Bypass passes TDI to TDO through one stage
// R9: Bypassed bit appears one TCK later
// R10: Bitstream always compressed, no disable option
// R11: Card pins released once in user mode
// R12: Scan pins also reach hard processor chain
// R13: Scan port may reprogram the attached flash
// R14: Request falling edge aborts scan, returns to select
// R15: During scan load, status follows request input
// R16: Scan load errors never pull status low
// R17: Select code picks card or scan-only path
package config_loader_pkg;

    // Boot-source select codes
    localparam logic [2:0] BOOT_CARD      = 3'h4;
    localparam logic [2:0] BOOT_SCAN_ONLY = 3'h7;

    // Synchronised pin vector layout
    localparam int PIN_NCFG   = 0;
    localparam int PIN_SEL    = 1;
    localparam int PIN_TCK    = 4;
    localparam int PIN_TMS    = 5;
    localparam int PIN_TDI    = 6;
    localparam int PIN_HP_TDO = 7;
    localparam int PIN_DATA   = 8;
    localparam int PIN_WIDTH  = 16;

    // Scan instruction register
    localparam int         IR_WIDTH   = 4;
    localparam logic [3:0] IR_BYPASS  = 4'hf;
    localparam logic [3:0] IR_CONFIG  = 4'h2;
    localparam logic [3:0] IR_FLASH   = 4'h3;
    localparam logic [3:0] IR_HP      = 4'h4;
    localparam logic [3:0] IR_CAPTURE = 4'h1;

    // Card timing: 50 MHz most, rounded up to whole half periods
    localparam int CLOCK_MHZ          = 125;
    localparam int CARD_MIN_PERIOD_NS = 20;
    localparam int CARD_HALF_CYC      = (CARD_MIN_PERIOD_NS * CLOCK_MHZ + 1999) / 2000;
    localparam logic [3:0] CARD_HALF_LAST = 4'(CARD_HALF_CYC - 1);

    // Card multiple-block read frame: start, host, index, argument, check, end
    localparam logic [47:0] READ_CMD_FRAME = 48'h520000_0000_5f;
    localparam logic [5:0]  CMD_LAST       = 6'h2f;
    localparam logic [9:0]  BLOCK_LAST     = 10'h1ff;
    localparam logic [5:0]  CRC_LAST       = 6'h10;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR,
        UP_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
    } tap_t;

    typedef enum logic [2:0] {LD_IDLE, LD_CMD, LD_WAIT, LD_DATA, LD_CRC} load_t;

endpackage

// ---- logic/config_loader.sv ----
// Configuration source loader: card reader, scan port and flags
`timescale 1ns/1ps
`default_nettype none

module config_loader
    import config_loader_pkg::*;
#(
    parameter bit HP_PRESENT = 1'b1
)(
    input  wire logic       clock,                   // System clock
    input  wire logic       rst_n,                   // Async reset, active low
    input  wire logic       enable,                  // Clock enable
    input  wire logic       config_request_n,        // Configuration request pin
    input  wire logic [2:0] boot_source_select,      // Boot source pins
    input  wire logic       scan_locked,             // Security lock of scan port
    input  wire logic       mmc_wide,                // Card is eight bits wide
    input  wire logic       tck,                     // Scan clock pin
    input  wire logic       tms,                     // Scan mode pin
    input  wire logic       tdi,                     // Scan data in pin
    output logic            tdo,                     // Scan data out
    output logic            tdo_oe_n,                // Scan out enable, low drives
    output logic            hp_tck,                  // Processor chain clock
    output logic            hp_tms,                  // Processor chain mode
    output logic            hp_tdi,                  // Processor chain data
    input  wire logic       hp_tdo,                  // Processor chain return
    output logic            card_clk,                // Card clock
    output logic            card_cmd,                // Card command line
    input  wire logic [7:0] card_data_in,            // Card data pins in
    output logic [7:0]      card_data_out,           // Card data pins out
    output logic            card_data_oe_n,          // Card data enable, low drives
    output logic [7:0]      stream_data,             // Bitstream byte
    output logic            stream_valid,            // Bitstream byte strobe
    output logic            stream_to_flash,         // Byte targets flash
    output logic            stream_compressed,       // Stream is compressed
    input  wire logic       bitstream_end,           // Engine saw full bitstream
    input  wire logic       bitstream_error,         // Engine saw an error
    input  wire logic       user_mode_entered,       // Fabric fully in user mode
    output logic            bitstream_received_flag, // Bitstream received
    output logic            user_mode_flag,          // Device in user mode
    output logic            config_state_low,        // Status, low on fault
    output logic            pins_released            // Card pins free for user
);

    typedef struct packed {
        logic [PIN_WIDTH-1:0] sync1;
        logic [PIN_WIDTH-1:0] sync2;
        logic                 tck_prev;
        logic                 ncfg_prev;
        tap_t                 tap;
        logic [IR_WIDTH-1:0]  ir;
        logic [IR_WIDTH-1:0]  ir_sh;
        logic                 byp;
        logic [7:0]           dr_sh;
        logic [2:0]           dr_cnt;
        logic                 scan_cfg;
        logic                 tdo;
        logic                 tdo_oe_n;
        logic                 hp_tck;
        logic                 hp_tms;
        logic                 hp_tdi;
        load_t                load;
        logic [3:0]           div;
        logic                 card_clk;
        logic                 card_cmd;
        logic [47:0]          cmd_sh;
        logic [5:0]           cnt;
        logic [3:0]           nib;
        logic                 nib_half;
        logic [9:0]           bytes;
        logic                 card_fault;
        logic [7:0]           data;
        logic                 valid;
        logic                 to_flash;
        logic                 compressed;
        logic                 received;
        logic                 user_mode;
        logic                 status;
        logic                 released;
    } state_t;

    state_t st;
    state_t next_st;

    // Reset image of the state
    function automatic state_t reset_value();
        state_t r;
        r            = '0;
        r.tap        = TLR;
        r.ir         = IR_BYPASS;
        r.tdo_oe_n   = 1'b1;
        r.card_cmd   = 1'b1;
        r.load       = LD_IDLE;
        r.compressed = 1'b1;
        return r;
    endfunction

    // Standard scan controller transitions
    function automatic tap_t tap_step(input tap_t s, input logic m);
        tap_t t;
        t = s;
        unique case (s)
            TLR:    t = m ? TLR : RTI;
            RTI:    t = m ? SEL_DR : RTI;
            SEL_DR: t = m ? SEL_IR : CAP_DR;
            CAP_DR: t = m ? EX1_DR : SH_DR;
            SH_DR:  t = m ? EX1_DR : SH_DR;
            EX1_DR: t = m ? UP_DR : PA_DR;
            PA_DR:  t = m ? EX2_DR : PA_DR;
            EX2_DR: t = m ? UP_DR : SH_DR;
            UP_DR:  t = m ? SEL_DR : RTI;
            SEL_IR: t = m ? TLR : CAP_IR;
            CAP_IR: t = m ? EX1_IR : SH_IR;
            SH_IR:  t = m ? EX1_IR : SH_IR;
            EX1_IR: t = m ? UP_IR : PA_IR;
            PA_IR:  t = m ? EX2_IR : PA_IR;
            EX2_IR: t = m ? UP_IR : SH_IR;
            UP_IR:  t = m ? SEL_DR : RTI;
        endcase
        return t;
    endfunction

    //--------------------------------------------------------------
    // Decoded pins and edges
    //--------------------------------------------------------------
    logic       ncfg;
    logic       ncfg_fall;
    logic       tck_rise;
    logic       tck_fall;
    logic [2:0] sel;
    logic [7:0] dat;
    logic [3:0] ir_eff;
    logic       card_tick;
    logic       card_rise;
    logic       card_fall;

    // Edges seen on the second synchroniser stage only
    assign ncfg      = st.sync2[PIN_NCFG];
    assign ncfg_fall = st.ncfg_prev & ~ncfg;
    assign tck_rise  = st.sync2[PIN_TCK] & ~st.tck_prev;
    assign tck_fall  = ~st.sync2[PIN_TCK] & st.tck_prev;
    assign sel       = st.sync2[PIN_SEL +: 3];
    assign dat       = st.sync2[PIN_DATA +: 8];
    assign card_tick = (st.load != LD_IDLE) && (st.div == CARD_HALF_LAST);
    assign card_rise = card_tick & ~st.card_clk;
    assign card_fall = card_tick & st.card_clk;

    // Locked or absent targets fall back to bypass
    always_comb
    begin
        ir_eff = st.ir;
        if (scan_locked && (st.ir == IR_CONFIG || st.ir == IR_FLASH || st.ir == IR_HP))
            ir_eff = IR_BYPASS; // R6
        if (!HP_PRESENT && st.ir == IR_HP)
            ir_eff = IR_BYPASS;
    end

    //--------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------
    always_comb
    begin
        next_st           = st;
        next_st.sync1     = {card_data_in, hp_tdo, tdi, tms, tck, boot_source_select, config_request_n};
        next_st.sync2     = st.sync1;
        next_st.tck_prev  = st.sync2[PIN_TCK];
        next_st.ncfg_prev = ncfg;
        next_st.valid     = 1'b0;

        // Scan controller on rising scan clock
        if (tck_rise)
        begin
            next_st.tap = tap_step(st.tap, st.sync2[PIN_TMS]);
            unique case (st.tap)
                TLR:
                begin
                    next_st.ir       = IR_BYPASS;
                    next_st.scan_cfg = 1'b0;
                end
                CAP_IR: next_st.ir_sh = IR_CAPTURE;
                SH_IR:  next_st.ir_sh = {st.sync2[PIN_TDI], st.ir_sh[IR_WIDTH-1:1]};
                UP_IR:  next_st.ir = st.ir_sh;
                CAP_DR:
                begin
                    next_st.byp    = 1'b0;
                    next_st.dr_cnt = 3'h0;
                end
                SH_DR:
                begin
                    if (ir_eff == IR_CONFIG || ir_eff == IR_FLASH)
                    begin
                        next_st.dr_sh  = {st.sync2[PIN_TDI], st.dr_sh[7:1]};
                        next_st.dr_cnt = st.dr_cnt + 3'h1;
                        next_st.scan_cfg = (ir_eff == IR_CONFIG); // R5
                        if (st.dr_cnt == 3'h7)
                        begin
                            next_st.data     = {st.sync2[PIN_TDI], st.dr_sh[7:1]};
                            next_st.valid    = 1'b1;
                            next_st.to_flash = (ir_eff == IR_FLASH); // R13
                        end
                    end
                    else
                        next_st.byp = st.sync2[PIN_TDI]; // R8
                end
                default: ;
            endcase
        end

        // Scan output changes on falling scan clock
        if (tck_fall)
        begin
            next_st.tdo_oe_n = !(st.tap == SH_DR || st.tap == SH_IR);
            if (st.tap == SH_IR)
                next_st.tdo = st.ir_sh[0];
            else if (ir_eff == IR_CONFIG || ir_eff == IR_FLASH)
                next_st.tdo = st.dr_sh[0];
            else if (ir_eff == IR_HP)
                next_st.tdo = st.sync2[PIN_HP_TDO]; // R12
            else
                next_st.tdo = st.byp; // R9
        end

        // Processor chain follows the scan pins while selected
        next_st.hp_tck = (ir_eff == IR_HP) & st.sync2[PIN_TCK]; // R12
        next_st.hp_tms = (ir_eff == IR_HP) & st.sync2[PIN_TMS];
        next_st.hp_tdi = (ir_eff == IR_HP) & st.sync2[PIN_TDI];

        // Card clock divider
        if (st.load != LD_IDLE)
        begin
            next_st.div = card_tick ? 4'h0 : st.div + 4'h1;
            if (card_tick)
                next_st.card_clk = ~st.card_clk;
        end
        else
        begin
            next_st.div      = 4'h0;
            next_st.card_clk = 1'b0;
            next_st.card_cmd = 1'b1;
        end

        // Card loader
        unique case (st.load)
            LD_IDLE:
                if (ncfg && sel == BOOT_CARD && !st.scan_cfg && !st.received && !st.card_fault) // R17
                begin
                    next_st.load   = LD_CMD; // R1
                    next_st.cmd_sh = READ_CMD_FRAME;
                    next_st.cnt    = 6'h0;
                end
            LD_CMD:
                if (card_fall)
                begin
                    next_st.card_cmd = st.cmd_sh[47];
                    next_st.cmd_sh   = {st.cmd_sh[46:0], 1'b1};
                    next_st.cnt      = st.cnt + 6'h1;
                    if (st.cnt == CMD_LAST)
                        next_st.load = LD_WAIT;
                end
            LD_WAIT:
            begin
                if (card_fall)
                    next_st.card_cmd = 1'b1;
                if (card_rise && !dat[0])
                begin
                    next_st.load     = LD_DATA;
                    next_st.bytes    = 10'h0;
                    next_st.nib_half = 1'b0;
                end
            end
            LD_DATA:
                if (card_rise)
                begin
                    if (mmc_wide || st.nib_half) // R2
                    begin
                        next_st.data     = mmc_wide ? dat : {st.nib, dat[3:0]};
                        next_st.valid    = 1'b1;
                        next_st.to_flash = 1'b0;
                        next_st.nib_half = 1'b0;
                        next_st.bytes    = st.bytes + 10'h1;
                        if (st.bytes == BLOCK_LAST)
                        begin
                            next_st.load = LD_CRC;
                            next_st.cnt  = 6'h0;
                        end
                    end
                    else
                    begin
                        next_st.nib      = dat[3:0];
                        next_st.nib_half = 1'b1;
                    end
                end
            LD_CRC:
                if (card_rise)
                begin
                    next_st.cnt = st.cnt + 6'h1;
                    if (st.cnt == CRC_LAST)
                        next_st.load = LD_WAIT;
                end
        endcase

        // Engine results; scan errors stay off the status pin
        if (bitstream_error && !st.scan_cfg)
            next_st.card_fault = 1'b1;
        if (bitstream_end && !bitstream_error)
            next_st.received = 1'b1; // R3
        if (bitstream_end || bitstream_error || st.scan_cfg)
            next_st.load = LD_IDLE; // R5
        if (user_mode_entered && st.received)
            next_st.user_mode = 1'b1; // R4
        next_st.released   = st.user_mode; // R11
        next_st.compressed = 1'b1; // R10

        // Status pin
        if (st.scan_cfg)
            next_st.status = ncfg; // R15 R16
        else
            next_st.status = ncfg & ~st.card_fault;

        // Request low clears progress; its falling edge ends scan access
        if (!ncfg)
        begin
            next_st.load       = LD_IDLE;
            next_st.received   = 1'b0;
            next_st.user_mode  = 1'b0;
            next_st.released   = 1'b0;
            next_st.card_fault = 1'b0;
        end
        if (ncfg_fall)
        begin
            next_st.tap      = TLR; // R14
            next_st.ir       = IR_BYPASS;
            next_st.scan_cfg = 1'b0;
            next_st.tdo_oe_n = 1'b1;
        end
    end

    //--------------------------------------------------------------
    // State register
    //--------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            st <= reset_value();
        else if (enable)
            st <= next_st;
    end

    // Outputs straight from the state; card data pins tied off, never driven
    assign tdo                     = st.tdo;
    assign tdo_oe_n                = st.tdo_oe_n;
    assign hp_tck                  = st.hp_tck;
    assign hp_tms                  = st.hp_tms;
    assign hp_tdi                  = st.hp_tdi;
    assign card_clk                = st.card_clk;
    assign card_cmd                = st.card_cmd;
    assign card_data_out           = 8'h00;
    assign card_data_oe_n          = 1'b1;
    assign stream_data             = st.data;
    assign stream_valid            = st.valid;
    assign stream_to_flash         = st.to_flash;
    assign stream_compressed       = st.compressed;
    assign bitstream_received_flag = st.received;
    assign user_mode_flag          = st.user_mode;
    assign config_state_low        = st.status;
    assign pins_released           = st.released;

endmodule

`default_nettype wire

// ---- verification/config_loader_chk.sv ----
// Port checker for the configuration source loader
`timescale 1ns/1ps
`default_nettype none

module config_loader_chk (
    input  wire logic clock,                   // System clock
    input  wire logic rst_n,                   // Async reset, active low
    input  wire logic config_request_n,        // Request pin
    input  wire logic scan_locked,             // Scan port lock
    input  wire logic bitstream_end,           // Engine end pulse
    input  wire logic bitstream_error,         // Engine error pulse
    input  wire logic user_mode_entered,       // Fabric in user mode
    input  wire logic stream_valid,            // Byte strobe
    input  wire logic stream_to_flash,         // Byte targets flash
    input  wire logic stream_compressed,       // Stream compressed
    input  wire logic bitstream_received_flag, // Bitstream received
    input  wire logic user_mode_flag,          // User mode
    input  wire logic config_state_low,        // Status, low on fault
    input  wire logic pins_released            // Card pins free
);
    // ----------------------------------------
    // Properties, all in the system clock domain
    // ----------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    compressed_a: assert property (stream_compressed)
        else $error("stream not marked compressed");
    received_cause_a: assert property ($rose(bitstream_received_flag) |->
        $past(bitstream_end) && !$past(bitstream_error)) else $error("received flag without clean end");
    user_mode_cause_a: assert property ($rose(user_mode_flag) |->
        $past(user_mode_entered) && $past(bitstream_received_flag)) else $error("user mode flag early");
    user_mode_order_a: assert property (user_mode_flag |-> bitstream_received_flag)
        else $error("user mode flag without received flag");
    pins_free_a: assert property ($rose(user_mode_flag) |=> pins_released)
        else $error("card pins not released");
    byte_pulse_a: assert property (stream_valid |=> !stream_valid)
        else $error("byte strobe longer than one cycle");
    status_follow_a: assert property ($fell(config_request_n) |-> ##[1:4] !config_state_low)
        else $error("status did not follow request");
    flash_lock_a: assert property (scan_locked |-> !(stream_valid && stream_to_flash))
        else $error("flash byte while scan port locked");
endmodule

`default_nettype wire

// ---- verification/card_model.sv ----
// Memory card model answering multiple-block reads
`timescale 1ns/1ps
`default_nettype none

module card_model (
    input  wire logic   card_clk,  // Card clock
    input  wire logic   card_cmd,  // Command line
    input  wire logic   mmc_wide,  // Eight-bit card
    input  wire logic   rearm,     // Abandon transfer, await a new frame
    output logic [7:0]  card_data, // Data pins, pulled up when idle
    output logic [47:0] cmd_seen   // Last command frame
);
    int         n;
    logic [7:0] b;

    // ----------------------------------------
    // Frame capture, then blocks of 512 bytes with start, check and end bits
    // ----------------------------------------
    initial cmd_seen = '0;
    initial forever
    begin : serve
        card_data = 8'hff;
        n = 0;
        @(negedge card_cmd);
        repeat (48) @(posedge card_clk) cmd_seen = {cmd_seen[46:0], card_cmd};
        repeat (2) @(negedge card_clk);
        forever
        begin
            @(negedge card_clk) card_data = 8'h00;
            for (int i = 0; i < 512; i++)
            begin
                b = 8'(n * 7 + 3);
                n++;
                if (mmc_wide)
                    @(negedge card_clk) card_data = b;
                else
                begin
                    @(negedge card_clk) card_data = {4'hf, b[7:4]}; // High nibble first
                    @(negedge card_clk) card_data = {4'hf, b[3:0]};
                end
            end
            repeat (16) @(negedge card_clk) card_data = ~card_data; // Check bits
            @(negedge card_clk) card_data = 8'hff;
            repeat (2) @(negedge card_clk);
        end
    end

    // Restart when the bench says the old transfer is over
    always @(posedge rearm) disable serve;
endmodule

`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking bench for the configuration source loader
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import config_loader_pkg::*;

    logic        clock, rst_n, enable, config_request_n, scan_locked, mmc_wide, tck, tms, tdi, hp_tdo;
    logic        bitstream_end, bitstream_error, user_mode_entered, rearm, b;
    logic        tdo, tdo_oe_n, hp_tck, hp_tms, hp_tdi, card_clk, card_cmd, card_data_oe_n, stream_valid;
    logic        stream_to_flash, stream_compressed, bitstream_received_flag, user_mode_flag;
    logic        config_state_low, pins_released;
    logic [2:0]  boot_source_select;
    logic [7:0]  card_data, card_data_out, stream_data;
    logic [15:0] q;
    logic [47:0] cmd_seen;
    logic [8:0]  got[$];
    int          mismatches, tests_run, n0;

    config_loader u_config_loader (.clock(clock), .rst_n(rst_n), .enable(enable),
        .config_request_n(config_request_n), .boot_source_select(boot_source_select),
        .scan_locked(scan_locked), .mmc_wide(mmc_wide), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .hp_tck(hp_tck), .hp_tms(hp_tms), .hp_tdi(hp_tdi), .hp_tdo(hp_tdo),
        .card_clk(card_clk), .card_cmd(card_cmd), .card_data_in(card_data), .card_data_out(card_data_out),
        .card_data_oe_n(card_data_oe_n), .stream_data(stream_data), .stream_valid(stream_valid),
        .stream_to_flash(stream_to_flash), .stream_compressed(stream_compressed),
        .bitstream_end(bitstream_end), .bitstream_error(bitstream_error),
        .user_mode_entered(user_mode_entered), .bitstream_received_flag(bitstream_received_flag),
        .user_mode_flag(user_mode_flag), .config_state_low(config_state_low), .pins_released(pins_released));

    card_model u_card_model (.card_clk(card_clk), .card_cmd(card_cmd), .mmc_wide(mmc_wide),
        .rearm(rearm), .card_data(card_data), .cmd_seen(cmd_seen));

    // ----------------------------------------
    // Clock, byte collection and shared tasks
    // ----------------------------------------
    always #4 clock = ~clock;

    // Every stream byte is kept together with its flash marker
    always @(posedge clock)
        if (stream_valid === 1'b1)
            got.push_back({stream_to_flash, stream_data});

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // One scan clock period of 160 ns; o is the output seen before the rise
    task automatic sbit(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        tick(10);
        o = tdo;
        tck = 1;
        tick(10);
        tck = 0;
    endtask

    // From idle through an instruction or data shift and back to idle
    task automatic scan(input logic ir, input int n, input logic [15:0] d);
        sbit(1, 0, b);
        if (ir)
            sbit(1, 0, b);
        sbit(0, 0, b);
        sbit(0, 0, b);
        for (int k = 0; k < n; k++)
        begin
            sbit(k == n - 1, d[k], q[k]);
            if (k == 0)
                check(tdo_oe_n, 0);
        end
        sbit(1, 0, b);
        sbit(0, 0, b);
    endtask

    task automatic pulse(input logic e, input logic r);
        bitstream_end = e;
        bitstream_error = r;
        tick(1);
        bitstream_end = 0;
        bitstream_error = 0;
        tick(3);
    endtask

    task automatic card_run(input logic wide, input int n);
        mmc_wide = wide;
        got.delete();
        config_request_n = 1;
        for (int k = 0; k < 20000 && got.size() < n; k++)
            tick(1);
        check(cmd_seen, READ_CMD_FRAME);
        for (int k = 0; k < n; k++)
            check(got[k], {1'b0, 8'(k * 7 + 3)});
    endtask

    initial
    begin
        #400000;
        mismatches++;
        conclude();
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial
    begin
        {clock, rst_n, scan_locked, mmc_wide, tck, tms, tdi, hp_tdo, rearm} = '0;
        {bitstream_end, bitstream_error, user_mode_entered, config_request_n} = '0;
        enable = 1;
        boot_source_select = 3'h7;
        tick(1);
        check(config_state_low, 0);
        tick(1);
        rst_n = 1;
        tick(3);
        check(stream_compressed, 1);
        config_request_n = 1;
        tick(250);
        check(cmd_seen, 48'h0);
        boot_source_select = BOOT_CARD;
        card_run(0, 600);
        pulse(1, 0);
        check(bitstream_received_flag, 1);
        check(user_mode_flag, 0);
        user_mode_entered = 1;
        tick(3);
        check(user_mode_flag, 1);
        check(pins_released, 1);
        config_request_n = 0;
        user_mode_entered = 0;
        tick(6);
        check(bitstream_received_flag, 0);
        rearm = 1;
        tick(1);
        rearm = 0;
        card_run(1, 40);
        pulse(1, 1);
        check(bitstream_received_flag, 0);
        check(config_state_low, 0);
        config_request_n = 0;
        boot_source_select = 3'h5;
        tick(6);
        rearm = 1;
        config_request_n = 1;
        tick(5);
        rearm = 0;
        check(config_state_low, 1);
        got.delete();
        repeat (5) sbit(1, 0, b);
        sbit(0, 0, b);
        scan(0, 8, 16'h00b5);
        check(q[7:0], 8'h6a);
        scan(1, 4, IR_CONFIG);
        scan(0, 16, 16'h3ca5);
        check(got.size(), 2);
        check(got[0], 9'h0a5);
        check(got[1], 9'h03c);
        pulse(0, 1);
        check(config_state_low, 1);
        scan(1, 4, IR_FLASH);
        scan(0, 8, 16'h00c3);
        check(got[2], 9'h1c3);
        scan(1, 4, IR_HP);
        hp_tdo = 1;
        sbit(0, 1, b);
        sbit(0, 1, b);
        check({hp_tck, hp_tms, hp_tdi}, 3'h5);
        check(tdo, 1);
        hp_tdo = 0;
        sbit(0, 1, b);
        sbit(0, 1, b);
        check(tdo, 0);
        scan_locked = 1;
        scan(1, 4, IR_CONFIG);
        n0 = got.size();
        scan(0, 8, 16'h00b5);
        check(got.size(), n0);
        check(q[7:0], 8'h6a);
        scan_locked = 0;
        scan(1, 4, IR_CONFIG);
        config_request_n = 0;
        tick(6);
        check(config_state_low, 0);
        config_request_n = 1;
        tick(6);
        sbit(0, 0, b);
        scan(0, 8, 16'h00b5);
        check(q[7:0], 8'h6a);
        check(got.size(), n0);
        conclude();
    end
endmodule

bind config_loader config_loader_chk u_config_loader_chk (.clock(clock), .rst_n(rst_n),
    .config_request_n(config_request_n), .scan_locked(scan_locked), .bitstream_end(bitstream_end),
    .bitstream_error(bitstream_error), .user_mode_entered(user_mode_entered), .stream_valid(stream_valid),
    .stream_to_flash(stream_to_flash), .stream_compressed(stream_compressed),
    .bitstream_received_flag(bitstream_received_flag), .user_mode_flag(user_mode_flag),
    .config_state_low(config_state_low), .pins_released(pins_released));

`default_nettype wire
